// >>> design/afcd_pkg.sv
// package: setup word layout, mode codes and decoded front-end bundle
package afcd_pkg;

  // ****************************************************************
  // setup word layout
  // ****************************************************************
  localparam int unsigned CFG_WIDTH = 14;
  localparam int unsigned TOPO_MSB = 12;
  localparam int unsigned TOPO_LSB = 10;
  localparam int unsigned CHAN_MSB = 9;
  localparam int unsigned CHAN_LSB = 7;
  localparam int unsigned FILTER_PASSBAND_BIT = 6;
  localparam int unsigned REF_MSB = 5;
  localparam int unsigned REF_LSB = 3;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 14'h3FFF;

  // ****************************************************************
  // topology codes
  // ****************************************************************
  localparam logic [2:0] TOPO_SINGLE_GND = 3'h7;
  localparam logic [2:0] TOPO_COM_BIPOLAR = 3'h2;
  localparam logic [2:0] TOPO_COM_GND_SENSE = 3'h6;
  localparam logic [1:0] TOPO_PAIR_BIPOLAR = 2'h0;
  localparam logic [1:0] TOPO_PAIR_UNIPOLAR = 2'h2;

  // ****************************************************************
  // reference scheme codes, six schemes
  // ****************************************************************
  localparam logic [2:0] REF_INT_2V5 = 3'h0;
  localparam logic [2:0] REF_INT_4V096 = 3'h1;
  localparam logic [2:0] REF_EXT_BUF_TEMP = 3'h2;
  localparam logic [2:0] REF_EXT_BUF = 3'h3;
  localparam logic [2:0] REF_EXT_TEMP = 3'h4;
  localparam logic [2:0] REF_EXT_DIRECT = 3'h5;

  typedef enum logic [2:0] {
    AFCD_SINGLE_GND = 3'b000,
    AFCD_COM_BIPOLAR = 3'b001,
    AFCD_COM_GND_SENSE = 3'b010,
    AFCD_PAIR_BIPOLAR = 3'b011,
    AFCD_PAIR_UNIPOLAR = 3'b100,
    AFCD_TOPO_OFF = 3'b101
  } afcd_topo_e;

  typedef enum logic [1:0] {
    AFCD_NEG_GND = 2'b00,
    AFCD_NEG_COM = 2'b01,
    AFCD_NEG_PAIR = 2'b10
  } afcd_neg_e;

  typedef struct packed {
    afcd_topo_e topo;
    afcd_neg_e neg_kind;
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
    logic twos_complement;
    logic filter_quarter;
    logic int_ref_en;
    logic ref_4v096;
    logic buf_en;
    logic temp_en;
  } afcd_front_s;

endpackage

// >>> design/afcd_shift.sv
// serial setup word shifter: catches one word per select window
`timescale 1ns/1ps

module afcd_shift #(
  parameter int unsigned WIDTH = 14
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_select_n,
  input wire logic i_sck_rise,
  input wire logic i_data,
  output logic [WIDTH-1:0] o_word,
  output logic o_word_valid
);

  logic [WIDTH-1:0] shift;
  logic [4:0] count;

  // msb first; only the first WIDTH edges of a window are taken
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      shift <= '0;
      count <= 5'h00;
    end else if (i_select_n) begin
      count <= 5'h00;
    end else if (i_sck_rise && count < 5'(WIDTH)) begin
      shift <= {shift[WIDTH-2:0], i_data};
      count <= count + 5'h01;
    end
  end

  // one-cycle pulse once the last bit is in
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_word <= '0;
      o_word_valid <= 1'b0;
    end else begin
      o_word_valid <= 1'b0;
      if (!i_select_n && i_sck_rise && count == 5'(WIDTH - 1)) begin
        o_word <= {shift[WIDTH-2:0], i_data};
        o_word_valid <= 1'b1;
      end
    end
  end

endmodule

// >>> design/afcd_decode.sv
// front-end setup decoder: holds the setup word and drives mux/ref enables
//
// Contract
// RL1: filter passband bit picks full or quarter input filter bandwidth.
// RL2: host slows conversion to a quarter when quarter bandwidth is on.
// RL3: topology 111 makes every input single-ended to ground.
// RL4: topology 010 measures inputs against common at half reference, bipolar.
// RL5: topology 110 measures inputs against common as ground sense, unipolar.
// RL6: topology 00x converts adjacent pairs bipolar, negative at half reference.
// RL7: topology 10x converts adjacent pairs unipolar, negative as ground sense.
// RL8: channel field picks pair; its parity picks which member is positive.
// RL9: sequencer scanning pairs always uses even inputs as positive.
// RL10: topology and channel may differ on every conversion.
// RL11: internal reference gives either 2.5 V or 4.096 V.
// RL12: reference field encodes six schemes with their own enables.
// RL13: internal reference on also turns on the temperature sensor.
// RL14: host keeps internal reference on when it needs temperature.
// RL15: temperature conversion result is straight binary from ground.
// RL16: external reference with buffer works with sensor on or off.
// RL17: host picks the all-off scheme when driving reference directly.
// RL18: lowest topology bit is ignored in both paired encodings.
// RL19: all front-end settings live in a fourteen-bit serial setup word.
// RL20: a word written in conversion n applies from conversion n+1.
`timescale 1ns/1ps

module afcd_decode #(
  parameter int unsigned WIDTH = afcd_pkg::CFG_WIDTH
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_select_n,
  input wire logic i_sck_rise,
  input wire logic i_data,
  input wire logic i_conv_done,
  input wire logic i_seq_active,
  input wire logic [2:0] i_seq_channel,
  input wire logic i_temp_request,
  output logic [WIDTH-1:0] o_active_word,
  output afcd_pkg::afcd_front_s o_front,
  output logic o_pending
);

  // ****************************************************************
  // word capture and staging
  // ****************************************************************
  logic [WIDTH-1:0] rx_word;
  logic rx_valid;
  logic [WIDTH-1:0] staged;
  logic staged_full;
  afcd_pkg::afcd_front_s next_front;

  afcd_shift #(
    .WIDTH(WIDTH)
  ) u_shift (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_select_n(i_select_n),
    .i_sck_rise(i_sck_rise),
    .i_data(i_data),
    .o_word(rx_word),
    .o_word_valid(rx_valid)
  );

  // a fresh word waits here so the conversion in flight keeps its setup
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      staged <= afcd_pkg::CFG_RESET;
      staged_full <= 1'b0;
    end else if (rx_valid) begin
      staged <= rx_word; // [RL19]
      staged_full <= 1'b1; // set wins over the commit below
    end else if (i_conv_done) begin
      staged_full <= 1'b0;
    end
  end

  // commit at the end of conversion n, so acquisition n+1 sees it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_active_word <= afcd_pkg::CFG_RESET;
    end else if (i_conv_done && staged_full) begin
      o_active_word <= staged; // [RL20] [RL10]
    end
  end

  // a word landing in the same cycle as the commit is held for the next
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pending <= 1'b0;
    end else begin
      o_pending <= rx_valid | (staged_full & ~i_conv_done);
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // positive member of a pair; scanning forces the even input
  function automatic logic [2:0] pair_positive(
    input logic [2:0] chan,
    input logic scanning
  );
    pair_positive = scanning ? {chan[2:1], 1'b0} : chan;
  endfunction

  // partner input of a pair
  function automatic logic [2:0] pair_partner(input logic [2:0] pos);
    pair_partner = {pos[2:1], ~pos[0]};
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  // mux topology, polarity and reference enables from the active word
  always_comb begin
    logic [2:0] topo;
    logic [2:0] chan;
    logic [2:0] refsel;
    topo = o_active_word[afcd_pkg::TOPO_MSB:afcd_pkg::TOPO_LSB];
    chan = i_seq_active ? i_seq_channel
        : o_active_word[afcd_pkg::CHAN_MSB:afcd_pkg::CHAN_LSB];
    refsel = o_active_word[afcd_pkg::REF_MSB:afcd_pkg::REF_LSB];
    next_front = '0;
    next_front.filter_quarter =
        o_active_word[afcd_pkg::FILTER_PASSBAND_BIT]; // [RL1]
    next_front.pos_ch = chan;
    next_front.neg_ch = 3'h0;
    next_front.topo = afcd_pkg::AFCD_TOPO_OFF;
    next_front.neg_kind = afcd_pkg::AFCD_NEG_GND;
    next_front.twos_complement = 1'b0;
    if (topo == afcd_pkg::TOPO_SINGLE_GND) begin
      next_front.topo = afcd_pkg::AFCD_SINGLE_GND; // [RL3]
    end else if (topo == afcd_pkg::TOPO_COM_BIPOLAR) begin
      next_front.topo = afcd_pkg::AFCD_COM_BIPOLAR; // [RL4]
      next_front.neg_kind = afcd_pkg::AFCD_NEG_COM;
      next_front.twos_complement = 1'b1;
    end else if (topo == afcd_pkg::TOPO_COM_GND_SENSE) begin
      next_front.topo = afcd_pkg::AFCD_COM_GND_SENSE; // [RL5]
      next_front.neg_kind = afcd_pkg::AFCD_NEG_COM;
    end else if (topo[2:1] == afcd_pkg::TOPO_PAIR_BIPOLAR) begin
      next_front.topo = afcd_pkg::AFCD_PAIR_BIPOLAR; // [RL6] [RL18]
      next_front.neg_kind = afcd_pkg::AFCD_NEG_PAIR;
      next_front.twos_complement = 1'b1;
      next_front.pos_ch = pair_positive(chan, i_seq_active); // [RL8] [RL9]
      next_front.neg_ch = pair_partner(next_front.pos_ch);
    end else if (topo[2:1] == afcd_pkg::TOPO_PAIR_UNIPOLAR) begin
      next_front.topo = afcd_pkg::AFCD_PAIR_UNIPOLAR; // [RL7] [RL18]
      next_front.neg_kind = afcd_pkg::AFCD_NEG_PAIR;
      next_front.pos_ch = pair_positive(chan, i_seq_active); // [RL8] [RL9]
      next_front.neg_ch = pair_partner(next_front.pos_ch);
    end
    // temperature result is unipolar whatever the topology says
    if (i_temp_request) begin
      next_front.twos_complement = 1'b0; // [RL15]
    end
    // reference schemes; spare codes fall to the lowest-power scheme
    unique case (refsel)
      afcd_pkg::REF_INT_2V5: begin
        next_front.int_ref_en = 1'b1; // [RL11] [RL12]
        next_front.buf_en = 1'b1;
      end
      afcd_pkg::REF_INT_4V096: begin
        next_front.int_ref_en = 1'b1; // [RL11] [RL12]
        next_front.ref_4v096 = 1'b1;
        next_front.buf_en = 1'b1;
      end
      afcd_pkg::REF_EXT_BUF_TEMP: begin
        next_front.buf_en = 1'b1; // [RL16]
        next_front.temp_en = 1'b1;
      end
      afcd_pkg::REF_EXT_BUF: begin
        next_front.buf_en = 1'b1; // [RL16]
      end
      afcd_pkg::REF_EXT_TEMP: begin
        next_front.temp_en = 1'b1; // [RL12]
      end
      default: begin
        next_front.buf_en = 1'b0; // [RL12]
      end
    endcase
    // the sensor shares the bandgap, so it follows the reference
    if (next_front.int_ref_en) begin
      next_front.temp_en = 1'b1; // [RL13]
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // registered so the mux and reference controls never glitch
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_front <= '0;
    end else begin
      o_front <= next_front;
    end
  end

endmodule

// >>> tb/afcd_host.sv
// host model: shifts setup words into the decoder msb first
`timescale 1ns/1ps
module afcd_host (
  input wire logic i_clock,
  output logic o_select_n,
  output logic o_sck_rise,
  output logic o_data
);
  // idle: deselected, no clock pulses
  initial begin
    o_select_n = 1'b1;
    o_sck_rise = 1'b0;
    o_data = 1'b0;
  end
  // one bit per two cycles; data flips once taken so stale bits show
  task automatic send(input logic [13:0] w, input int n);
    @(negedge i_clock) o_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge i_clock) o_sck_rise = 1'b1;
      o_data = w[13-i];
      @(negedge i_clock) o_sck_rise = 1'b0;
      o_data = ~o_data;
    end
    @(negedge i_clock) o_select_n = 1'b1;
  endtask
endmodule

// >>> tb/afcd_chk.sv
// checker: front-end decode and commit relations at the decoder ports
`timescale 1ns/1ps
module afcd_chk #(
  parameter int unsigned WIDTH = afcd_pkg::CFG_WIDTH
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_conv_done,
  input wire logic i_seq_active,
  input wire logic [2:0] i_seq_channel,
  input wire logic i_temp_request,
  input wire logic [WIDTH-1:0] o_active_word,
  input wire afcd_pkg::afcd_front_s o_front
);
  logic armed;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // front lags by one edge, so judge only from the second edge on
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end
  // topology code in force one edge earlier
  sequence s_topo(logic [2:0] c);
    armed && $past(o_active_word[12:10]) == c;
  endsequence
  // paired topology, channel from word or sequencer
  sequence s_pair(logic s);
    armed && !$past(o_active_word[11]) && $past(i_seq_active) == s;
  endsequence
  a_filter_band: assert property (armed |->
    o_front.filter_quarter == $past(o_active_word[6]))
    else $error("filter passband decode wrong");
  a_single_gnd: assert property (s_topo(3'h7) |->
    o_front.topo == afcd_pkg::AFCD_SINGLE_GND &&
    o_front.neg_kind == afcd_pkg::AFCD_NEG_GND)
    else $error("single-ended decode wrong");
  a_com_bipolar: assert property (s_topo(3'h2) |->
    o_front.topo == afcd_pkg::AFCD_COM_BIPOLAR &&
    o_front.twos_complement == !$past(i_temp_request))
    else $error("common bipolar decode wrong");
  a_com_sense: assert property (s_topo(3'h6) |->
    o_front.topo == afcd_pkg::AFCD_COM_GND_SENSE &&
    !o_front.twos_complement)
    else $error("common ground sense decode wrong");
  a_pair_pos: assert property (s_pair(1'b0) |->
    o_front.pos_ch == $past(o_active_word[9:7]) &&
    o_front.neg_kind == afcd_pkg::AFCD_NEG_PAIR)
    else $error("pair channel decode wrong");
  a_seq_even: assert property (s_pair(1'b1) |->
    o_front.pos_ch == {$past(i_seq_channel[2:1]), 1'b0} &&
    o_front.neg_ch == {$past(i_seq_channel[2:1]), 1'b1})
    else $error("sequencer pair not even-positive");
  a_ref_pick: assert property (armed |->
    o_front.ref_4v096 == ($past(o_active_word[5:3]) == 3'h1) &&
    (o_front.temp_en || !o_front.int_ref_en))
    else $error("reference decode wrong");
  a_commit_only: assert property ($changed(o_active_word) |->
    $past(i_conv_done))
    else $error("setup word changed outside end of conversion");
endmodule
bind afcd_decode afcd_chk #(.WIDTH(WIDTH)) chk_i (.i_clock(i_clock),
  .i_resetn(i_resetn), .i_conv_done(i_conv_done),
  .i_seq_active(i_seq_active), .i_seq_channel(i_seq_channel),
  .i_temp_request(i_temp_request), .o_active_word(o_active_word),
  .o_front(o_front));

// >>> tb/afcd_decode_tb.sv
// bench: setup word loading, commit timing and front-end decode
`timescale 1ns/1ps
module afcd_decode_tb;
  // expected {topo, neg_kind} and {int, 4v096, buf, temp} per code
  localparam logic [4:0] TEXP [8] = '{5'h0E, 5'h0E, 5'h05, 5'h14, 5'h12,
    5'h12, 5'h09, 5'h00};
  localparam logic [3:0] REXP [8] = '{4'hB, 4'hF, 4'h3, 4'h2, 4'h1, 4'h0,
    4'h0, 4'h0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cd = 1'b0;
  logic sa = 1'b0;
  logic [2:0] sc = 3'h0;
  logic tr = 1'b0;
  logic sel_n, sck, sd, pend;
  logic [13:0] aw;
  afcd_pkg::afcd_front_s f;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  afcd_host host (.i_clock(clk), .o_select_n(sel_n), .o_sck_rise(sck),
    .o_data(sd));
  afcd_decode dut (.i_clock(clk), .i_resetn(rst_n), .i_select_n(sel_n),
    .i_sck_rise(sck), .i_data(sd), .i_conv_done(cd), .i_seq_active(sa),
    .i_seq_channel(sc), .i_temp_request(tr), .o_active_word(aw),
    .o_front(f), .o_pending(pend));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // cut a hung run short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end
  function automatic logic [13:0] mk(input logic [2:0] t,
    input logic [2:0] c, input logic b, input logic [2:0] r);
    return {1'b1, t, c, b, r, 3'h7};
  endfunction
  // end of conversion; pacing is far below full rate for quarter band
  task automatic conv;
    @(negedge clk) cd = 1'b1;
    @(negedge clk) cd = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic load(input logic [13:0] w);
    host.send(w, 14);
    for (int i = 0; i < 40 && !pend; i++) @(negedge clk);
    chk(pend, 1'b1);
    conv;
    chk(aw, w);
  endtask
  task automatic t_reset;
    chk(aw, afcd_pkg::CFG_RESET);
    chk({pend, f.topo, f.filter_quarter, f.int_ref_en}, 5'h02);
  endtask
  // every topology and reference code, one after another
  task automatic t_modes;
    logic [2:0] t;
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      t = 3'(k);
      c = ~t;
      load(mk(t, c, t[0], t));
      chk({f.topo, f.neg_kind}, TEXP[k]);
      chk(f.pos_ch, c);
      if (!t[1]) chk(f.neg_ch, c ^ 3'h1);
      chk(f.twos_complement, t < 3'h3);
      chk(f.filter_quarter, t[0]);
      c = {f.int_ref_en, f.ref_4v096, f.buf_en};
      chk({c, f.temp_en}, REXP[k]);
    end
  endtask
  // sequencer pairs are even-positive; a sensor read in common bipolar is straight binary with the sensor on
  task automatic t_seq;
    load(mk(3'h1, 3'h3, 1'b0, 3'h0));
    sa = 1'b1;
    for (int k = 0; k < 8; k++) begin
      sc = 3'(k);
      repeat (2) @(negedge clk);
      chk({f.pos_ch, f.neg_ch}, {sc & 3'h6, sc | 3'h1});
    end
    sa = 1'b0;
    load(mk(3'h2, 3'h0, 1'b0, 3'h0));
    tr = 1'b1;
    repeat (2) @(negedge clk);
    chk(f.twos_complement, 1'b0);
    chk(f.temp_en, 1'b1);
    tr = 1'b0;
  endtask
  // staged word waits; a partial word is dropped; idle commit is a no-op
  task automatic t_commit;
    load(mk(3'h7, 3'h1, 1'b0, 3'h3));
    host.send(mk(3'h6, 3'h2, 1'b1, 3'h4), 14);
    chk(aw, mk(3'h7, 3'h1, 1'b0, 3'h3));
    host.send(14'h0000, 10);
    conv;
    chk({pend, aw}, mk(3'h6, 3'h2, 1'b1, 3'h4));
    conv;
    chk(aw, mk(3'h6, 3'h2, 1'b1, 3'h4));
    // a newer word replaces the one still waiting
    host.send(mk(3'h0, 3'h4, 1'b0, 3'h1), 14);
    host.send(mk(3'h4, 3'h5, 1'b1, 3'h2), 14);
    conv;
    chk(aw, mk(3'h4, 3'h5, 1'b1, 3'h2));
    // end of conversion on the edge the word lands: it waits a round
    fork
      host.send(mk(3'h2, 3'h6, 1'b0, 3'h0), 14);
      begin
        repeat (29) @(negedge clk);
        cd = 1'b1;
        @(negedge clk) cd = 1'b0;
      end
    join
    chk({pend, aw}, {1'b1, mk(3'h4, 3'h5, 1'b1, 3'h2)});
    conv;
    chk({pend, aw}, {1'b0, mk(3'h2, 3'h6, 1'b0, 3'h0)});
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset;
    t_modes;
    t_seq;
    t_commit;
    final_report;
  end
endmodule
